// File: design/lpd_core.sv
`timescale 1ns/10ps
module lpd_core (
    // Core clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    // Link clock and command pins
    input  wire logic                                mem_clk,
    input  wire logic                                cke,
    input  wire logic                                cs_n,
    input  wire logic                                ras_n,
    input  wire logic                                cas_n,
    input  wire logic                                we_n,
    input  wire logic                                bank_sel_0,
    input  wire logic                                bank_sel_1,
    input  wire logic [lpddr_pkg::ADDR_W-1:0]        addr,
    // Data, one word per beat at link clock
    input  wire logic [lpddr_pkg::DATA_W-1:0]        dq_in,
    input  wire logic [lpddr_pkg::BYTES-1:0]         byte_mask,
    output logic      [lpddr_pkg::DATA_W-1:0]        dq_out,
    output logic                                     dq_oe,
    // Status
    output logic      [lpddr_pkg::BANKS-1:0]         bank_open,
    output logic      [lpddr_pkg::ADDR_W-1:0]        mode_reg,
    output logic      [lpddr_pkg::ADDR_W-1:0]        ext_mode_reg,
    output logic      [lpddr_pkg::ROW_W-1:0]         refresh_row,
    output logic                                     self_refresh,
    output logic                                     deep_power_down
);
    import lpddr_pkg::*;

    // Link-side reset: three flops, released once the last two agree
    logic lrst_s1;
    logic lrst_s2;
    logic lrst_s3;
    always_ff @(posedge mem_clk) begin
        lrst_s1 <= rst_n;
        lrst_s2 <= lrst_s1;
        lrst_s3 <= lrst_s2;
    end
    wire  lrst_n = lrst_s2 && lrst_s3;

    // Command decode from pins
    wire [2:0] cmd     = {ras_n, cas_n, we_n}; // nop decodes to nothing
    wire [1:0] bank    = {bank_sel_1, bank_sel_0};
    wire       sel     = !cs_n;
    wire       is_act  = sel && cke && cmd == CMD_ACT;
    wire       is_rd   = sel && cke && cmd == CMD_RD;
    wire       is_wr   = sel && cke && cmd == CMD_WR;
    wire       is_pre  = sel && cke && cmd == CMD_PRE;
    wire       is_aref = sel && cke && cmd == CMD_REF;
    wire       is_sref = sel && !cke && cmd == CMD_REF;
    wire       is_bst  = sel && cke && cmd == CMD_BST;
    wire       is_dpd  = sel && !cke && cmd == CMD_BST;
    wire       is_mrs  = sel && cke && cmd == CMD_MRS;
    wire       ap      = addr[AP_BIT];

    // Power state and per-bank tracking live on the link clock
    lpd_pwr_t         pwr;
    logic [BANKS-1:0] active;
    logic [BANKS-1:0] closing;
    logic [7:0]       ras_cnt [BANKS];
    logic [7:0]       rp_cnt  [BANKS];
    logic [BANKS-1:0] ap_pend;
    wire              normal  = pwr == LPD_NORMAL;

    // Burst engine
    logic             burst;
    logic             burst_wr;
    logic             burst_ap;
    logic [1:0]       burst_bank;
    logic [COL_W-1:0] col;
    logic [2:0]       beats;
    wire              burst_last = burst && beats == 3'(BURST_LEN - 1);
    wire              cut_burst  = normal && is_bst && burst && !burst_wr && !burst_ap;
    wire              new_burst  = normal && (is_rd || is_wr) && active[bank] && !closing[bank];

    // Precharge targets: explicit command, one bank or all banks when ap is set
    wire [BANKS-1:0] pre_mask;
    genvar g;
    generate
        for (g = 0; g < BANKS; g++) begin : g_pre
            assign pre_mask[g] = normal && is_pre && (ap || bank == 2'(g));
        end
    endgenerate

    // Per-bank state: open, closing, timers
    generate
        for (g = 0; g < BANKS; g++) begin : g_bank
            wire end_ap = burst_last && burst_ap && burst_bank == 2'(g);
            wire go_pre = (pre_mask[g] || ap_pend[g] || end_ap) && active[g]
                          && !closing[g] && ras_cnt[g] == 8'h00;
            always_ff @(posedge mem_clk) begin
                if (!lrst_n) begin
                    active[g]  <= 1'b0;
                    closing[g] <= 1'b0;
                    ap_pend[g] <= 1'b0;
                    ras_cnt[g] <= 8'h00;
                    rp_cnt[g]  <= 8'h00;
                end else if (!normal) begin
                    active[g]  <= 1'b0;
                    closing[g] <= 1'b0;
                    ap_pend[g] <= 1'b0;
                end else if (is_act && bank == 2'(g) && !active[g]) begin
                    active[g]  <= 1'b1;
                    ras_cnt[g] <= 8'(RAS_CYC);
                end else if (go_pre) begin
                    closing[g] <= 1'b1;
                    ap_pend[g] <= 1'b0;
                    rp_cnt[g]  <= 8'(RP_CYC);
                end else begin
                    if (end_ap) begin
                        ap_pend[g] <= 1'b1; // wait out active time
                    end
                    if (ras_cnt[g] != 8'h00) begin
                        ras_cnt[g] <= ras_cnt[g] - 8'h01;
                    end
                    if (closing[g]) begin
                        if (rp_cnt[g] == 8'h01) begin
                            active[g]  <= 1'b0;
                            closing[g] <= 1'b0;
                        end
                        rp_cnt[g] <= rp_cnt[g] - 8'h01;
                    end
                end
            end
        end
    endgenerate

    // Burst sequencing; other-bank command allowed after current one ends
    always_ff @(posedge mem_clk) begin
        if (!lrst_n) begin
            burst <= 1'b0;
            beats <= 3'h0;
        end else if (new_burst && !(burst && !burst_last)) begin
            burst <= 1'b1;
            beats <= 3'h0;
        end else if (cut_burst || burst_last || !normal) begin
            burst <= 1'b0;
        end else if (burst) begin
            beats <= beats + 3'h1;
        end
    end

    // Latch burst attributes at the command
    always_ff @(posedge mem_clk) begin
        if (!lrst_n) begin
            burst_wr   <= 1'b0;
            burst_ap   <= 1'b0;
            burst_bank <= 2'h0;
            col        <= '0;
        end else if (new_burst && !(burst && !burst_last)) begin
            burst_wr   <= is_wr;
            burst_ap   <= ap;
            burst_bank <= bank;
            col        <= addr[COL_W-1:0];
        end else if (burst) begin
            col <= col + 9'h001;
        end
    end

    // Array access: bank and column fold into the small model memory
    wire [MEM_AW-1:0] mem_addr = {burst_bank, col[MEM_AW-3:0]};
    wire [DATA_W-1:0] rdata;
    lpd_mem u_mem (
        .clk   (mem_clk),
        .we    (burst && burst_wr && normal),
        .waddr (mem_addr),
        .wdata (dq_in),
        .wmask (byte_mask),
        .raddr (mem_addr),
        .rdata (rdata)
    );

    // Read data drive; enable waits a stage to match the registered array read
    logic rd_beat;
    always_ff @(posedge mem_clk) begin
        if (!lrst_n) begin
            rd_beat <= 1'b0;
            dq_oe   <= 1'b0;
            dq_out  <= '0;
        end else begin
            rd_beat <= burst && !burst_wr && !cut_burst;
            dq_oe   <= rd_beat;
            dq_out  <= rdata;
        end
    end

    // Mode registers, power modes, refresh counter
    logic [ADDR_W-1:0] mode_l;
    logic [ADDR_W-1:0] emode_l;
    logic [ROW_W-1:0]  rrow;
    logic [7:0]        sref_tmr;
    wire               all_idle = active == '0;
    // Partial array: each step of the setting halves the rows swept
    wire [1:0]         partial_array_refresh_setting     = emode_l[1:0];
    wire [ROW_W-1:0]   partial_array_refresh_setting_rows = {ROW_W{1'b1}} >> partial_array_refresh_setting;
    always_ff @(posedge mem_clk) begin
        if (!lrst_n) begin
            mode_l   <= MODE_RST;
            emode_l  <= MODE_RST;
            rrow     <= '0;
            pwr      <= LPD_NORMAL;
            sref_tmr <= 8'h00;
        end else begin
            unique case (pwr)
                LPD_NORMAL: begin
                    if (is_mrs && all_idle && bank == MRS_STD) begin
                        mode_l <= addr;
                    end else if (is_mrs && all_idle && bank == MRS_EXT) begin
                        emode_l <= addr;
                    end else if (is_aref) begin
                        rrow <= rrow + 13'h0001;
                    end else if (is_sref && all_idle) begin
                        pwr <= LPD_SREF;
                    end else if (is_dpd && all_idle) begin
                        pwr <= LPD_DPD;
                    end
                end
                LPD_SREF: begin
                    // Internal oscillator paces refresh; partial_array_refresh_setting limits coverage
                    if (sref_tmr == 8'(SREF_INT_CYC - 1)) begin
                        sref_tmr <= 8'h00;
                        rrow     <= (rrow + 13'h0001) & partial_array_refresh_setting_rows;
                    end else begin
                        sref_tmr <= sref_tmr + 8'h01;
                    end
                    if (cke) begin
                        pwr <= LPD_NORMAL;
                    end
                end
                LPD_DPD: begin
                    // Array unpowered: both mode registers return to MODE_RST
                    mode_l  <= MODE_RST;
                    emode_l <= MODE_RST;
                    if (cke) begin
                        pwr <= LPD_NORMAL;
                    end
                end
            endcase
        end
    end

    // Status into ref_clk: three flops, change taken when last two agree
    localparam int SW = BANKS + 2 * ADDR_W + ROW_W + 2;
    wire [SW-1:0] stat_l = {active, mode_l, emode_l, rrow,
                            pwr == LPD_SREF, pwr == LPD_DPD};
    logic [SW-1:0] s1;
    logic [SW-1:0] s2;
    logic [SW-1:0] s3;
    always_ff @(posedge ref_clk) begin
        s1 <= stat_l;
        s2 <= s1;
        s3 <= s2;
    end
    // Whole word taken only when both stages agree, so no torn multi-bit value
    wire          agree = s2 == s3;
    wire [SW-1:0] next_stat = {bank_open, mode_reg, ext_mode_reg, refresh_row,
                               self_refresh, deep_power_down};
    wire [SW-1:0] upd = agree ? s3 : next_stat;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bank_open       <= '0;
            mode_reg        <= MODE_RST;
            ext_mode_reg    <= MODE_RST;
            refresh_row     <= '0;
            self_refresh    <= 1'b0;
            deep_power_down <= 1'b0;
        end else begin
            {bank_open, mode_reg, ext_mode_reg, refresh_row,
             self_refresh, deep_power_down} <= upd;
        end
    end

    // Checks on the link domain
    chk_act_opens: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (normal && is_act && !active[bank]) |=> active[$past(bank)])
        else $error("activate did not open bank");
    chk_desel_hold: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (cs_n && normal && !burst && closing == '0 && ap_pend == '0) |=> $stable(active))
        else $error("deselect changed bank state");
    chk_pre_idle_nop: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (normal && is_pre && !ap && !active[bank]) |=> !closing[$past(bank)])
        else $error("precharge of idle bank acted");
    chk_bst_stops: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        cut_burst |=> !burst ##1 !dq_oe)
        else $error("terminate did not stop read");
    chk_sref_enter: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (normal && is_sref && all_idle) |=> pwr == LPD_SREF)
        else $error("self refresh not entered");
    chk_aref_count: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (normal && is_aref) |=> rrow == $past(rrow) + 13'h0001)
        else $error("refresh counter not advanced");
    chk_ap_closes: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (burst_last && burst_ap && ras_cnt[burst_bank] == 8'h00)
        |=> closing[$past(burst_bank)])
        else $error("auto precharge did not start");
    chk_read_drive: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (burst && !burst_wr && !cut_burst) |-> ##2 dq_oe)
        else $error("read beat not driven");
    chk_dpd_enter: assert property (@(posedge mem_clk) disable iff (!lrst_n)
        (normal && is_dpd && all_idle) |=> pwr == LPD_DPD)
        else $error("deep power down not entered");
    cov_write: cover property (@(posedge mem_clk) disable iff (!lrst_n) burst && burst_wr);
    cov_ap: cover property (@(posedge mem_clk) disable iff (!lrst_n) burst_last && burst_ap);
    cov_sref: cover property (@(posedge mem_clk) disable iff (!lrst_n) pwr == LPD_SREF ##1 cke);
endmodule

// File: design/lpddr_pkg.sv
package lpddr_pkg;
    // Geometry
    localparam int BANKS      = 4;
    localparam int ROW_W      = 13;
    localparam int COL_W      = 9;
    localparam int ADDR_W     = 13;
    localparam int BYTES      = 4;
    localparam int DATA_W     = 32;
    localparam int MEM_AW     = 6;
    localparam int AP_BIT     = 10;
    localparam int BURST_LEN  = 4;

    // Timing in ns and derived cycles at 4 ns
    localparam int CLK_NS          = 4;
    localparam int T_RP_NS         = 15;
    localparam int T_RAS_NS        = 40;
    localparam int T_RFC_NS        = 72;
    localparam int T_MRD_NS        = 8;
    localparam int RP_CYC          = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_CYC         = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RFC_CYC         = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
    localparam int MRD_CYC         = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SREF_INT_CYC    = 64;

    // Mode register select
    localparam logic [1:0] MRS_STD = 2'h0;
    localparam logic [1:0] MRS_EXT = 2'h2;
    localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;

    // Command codes {ras_n,cas_n,we_n}
    localparam logic [2:0] CMD_NOP  = 3'h7;
    localparam logic [2:0] CMD_ACT  = 3'h3;
    localparam logic [2:0] CMD_RD   = 3'h5;
    localparam logic [2:0] CMD_WR   = 3'h4;
    localparam logic [2:0] CMD_BST  = 3'h6;
    localparam logic [2:0] CMD_PRE  = 3'h2;
    localparam logic [2:0] CMD_REF  = 3'h1;
    localparam logic [2:0] CMD_MRS  = 3'h0;

    typedef enum logic [2:0] {
        LPD_NORMAL, LPD_SREF, LPD_DPD
    } lpd_pwr_t;
endpackage

// File: design/lpd_mem.sv
`timescale 1ns/10ps
// Small byte-masked array with registered read
module lpd_mem (
    // Clock
    input  wire logic                                clk,
    // Write port
    input  wire logic                                we,
    input  wire logic [lpddr_pkg::MEM_AW-1:0]        waddr,
    input  wire logic [lpddr_pkg::DATA_W-1:0]        wdata,
    input  wire logic [lpddr_pkg::BYTES-1:0]         wmask,
    // Read port
    input  wire logic [lpddr_pkg::MEM_AW-1:0]        raddr,
    output logic      [lpddr_pkg::DATA_W-1:0]        rdata
);
    import lpddr_pkg::*;

    // One array per byte lane, so no two processes write the same array
    genvar b;
    generate
        for (b = 0; b < BYTES; b++) begin : g_lane
            logic [7:0] lane [0:(1<<MEM_AW)-1];
            always_ff @(posedge clk) begin
                if (we && !wmask[b]) begin
                    lane[waddr] <= wdata[8*b +: 8];
                end
                rdata[8*b +: 8] <= lane[raddr];
            end
        end
    endgenerate
endmodule

// File: test/lpd_ctl_model.sv
`timescale 1ns/10ps
// Controller-side model: drives command pins and write beats on mem_clk
module lpd_ctl_model (
    // Link clock
    input  wire logic                         mem_clk,
    // Command pins
    output logic                              cke,
    output logic                              cs_n,
    output logic                              ras_n,
    output logic                              cas_n,
    output logic                              we_n,
    output logic                              bank_sel_0,
    output logic                              bank_sel_1,
    output logic      [lpddr_pkg::ADDR_W-1:0] addr,
    // Write beats
    output logic      [lpddr_pkg::DATA_W-1:0] dq_in,
    output logic      [lpddr_pkg::BYTES-1:0]  byte_mask
);
    import lpddr_pkg::*;

    // Idle pins: deselected nop, data lines at a non-zero pattern
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
        {bank_sel_1, bank_sel_0} = 2'h0;
        addr = 13'h1555;
        dq_in = 32'h5A5A5A5A;
        byte_mask = 4'hA;
    end

    // One command, then a nop; address is scrambled once it has been sampled
    task automatic issue(input logic ck, input logic sel_n, input logic [2:0] code,
                         input logic [1:0] bank, input logic [ADDR_W-1:0] a);
        @(posedge mem_clk);
        cke <= ck;
        cs_n <= sel_n;
        {ras_n, cas_n, we_n} <= code;
        {bank_sel_1, bank_sel_0} <= bank;
        addr <= a;
        @(posedge mem_clk);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= CMD_NOP;
        addr <= ~a;
    endtask

    // Four write beats from the command edge on, then the lines are inverted
    task automatic beats(input logic [4*DATA_W-1:0] d, input logic [4*BYTES-1:0] m);
        for (int k = 0; k < 4; k++) begin
            if (k > 0) @(posedge mem_clk);
            dq_in <= d[k*DATA_W +: DATA_W];
            byte_mask <= m[k*BYTES +: BYTES];
        end
        @(posedge mem_clk);
        dq_in <= ~dq_in;
        byte_mask <= ~byte_mask;
    endtask

    // Waiting slot for precharge, refresh and exit times
    task automatic idle(input int n);
        repeat (n) @(posedge mem_clk);
    endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
// Command-level bench for the memory core
module tb_top;
    import lpddr_pkg::*;
    // Clocks, reset, pins
    logic              ref_clk;
    logic              mem_clk;
    logic              rst_n;
    logic              cke, cs_n, ras_n, cas_n, we_n, bank_sel_0, bank_sel_1, dq_oe;
    logic              self_refresh, deep_power_down;
    logic [ADDR_W-1:0] addr, mode_reg, ext_mode_reg;
    logic [ROW_W-1:0]  refresh_row, r0;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [BYTES-1:0]  byte_mask;
    logic [BANKS-1:0]  bank_open;
    logic [127:0]      d_a, d_b;
    int                mismatches;
    int                n_compared;

    // Link clock offset so the two domains never line up
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        mem_clk = 1'b0;
        #37.3;
        forever #62.5 mem_clk = ~mem_clk;
    end

    lpd_ctl_model u_ctl (.mem_clk(mem_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1),
        .addr(addr), .dq_in(dq_in), .byte_mask(byte_mask));

    lpd_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .mem_clk(mem_clk), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel_0(bank_sel_0),
        .bank_sel_1(bank_sel_1), .addr(addr), .dq_in(dq_in), .byte_mask(byte_mask),
        .dq_out(dq_out), .dq_oe(dq_oe), .bank_open(bank_open), .mode_reg(mode_reg),
        .ext_mode_reg(ext_mode_reg), .refresh_row(refresh_row),
        .self_refresh(self_refresh), .deep_power_down(deep_power_down));

    // Masked bytes keep the older word
    function automatic logic [127:0] merge(input logic [127:0] old_d, new_d,
                                           input logic [15:0] m);
        logic [127:0] r;
        for (int i = 0; i < 16; i++) r[i*8 +: 8] = m[i] ? old_d[i*8 +: 8] : new_d[i*8 +: 8];
        return r;
    endfunction

    // Status crosses into ref_clk, so look well after the next link edge
    task automatic settle();
        repeat (2) @(negedge mem_clk);
    endtask

    task automatic wr(input logic [1:0] b, input logic [ADDR_W-1:0] a,
                      input logic [127:0] d, input logic [15:0] m);
        u_ctl.issue(1'b1, 1'b0, CMD_WR, b, a);
        u_ctl.beats(d, m);
    endtask

    // Read burst: data drive starts two link edges after the command
    task automatic rd(input logic [1:0] b, input logic [ADDR_W-1:0] a, input logic [127:0] e);
        u_ctl.issue(1'b1, 1'b0, CMD_RD, b, a);
        repeat (2) @(posedge mem_clk);
        for (int k = 0; k < 4; k++) begin
            @(negedge mem_clk);
            `CHK(dq_oe, 1'b1)
            `CHK(dq_out, e[k*32 +: 32])
            @(posedge mem_clk);
        end
        @(negedge mem_clk);
        `CHK(dq_oe, 1'b0)
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 50 us
    initial begin
        #250000;
        mismatches++;
        stop_test();
    end

    initial begin
        mismatches = 0;
        n_compared = 0;
        rst_n = 1'b0;
        d_a = 128'h44434241_34333231_24232221_14131211;
        d_b = 128'hD4D3D2D1_C4C3C2C1_B4B3B2B1_A4A3A2A1;
        repeat (6) @(posedge mem_clk);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mem_clk);
        settle();
        `CHK(bank_open, 4'h0)
        // Deselected activate, then a real one and a nop
        u_ctl.issue(1'b1, 1'b1, CMD_ACT, 2'h2, 13'h0005);
        settle();
        `CHK(bank_open, 4'h0)
        u_ctl.issue(1'b1, 1'b0, CMD_ACT, 2'h1, 13'h0011);
        u_ctl.issue(1'b1, 1'b0, CMD_NOP, 2'h3, 13'h0400);
        settle();
        `CHK(bank_open, 4'h2)
        // Full write, masked overwrite, read back with row left open
        wr(2'h1, 13'h0008, d_a, 16'h0000);
        wr(2'h1, 13'h0008, d_b, 16'h8421);
        rd(2'h1, 13'h0008, merge(d_a, d_b, 16'h8421));
        settle();
        `CHK(bank_open, 4'h2)
        // Auto-precharged write on bank 1, bank 0 read meanwhile
        u_ctl.issue(1'b1, 1'b0, CMD_ACT, 2'h0, 13'h0022);
        wr(2'h0, 13'h0000, d_b, 16'h0000);
        wr(2'h1, 13'h0400, d_a, 16'h0000);
        rd(2'h0, 13'h0000, d_b);
        u_ctl.idle(RAS_CYC + RP_CYC);
        settle();
        `CHK(bank_open, 4'h1)
        rd(2'h0, 13'h0400, d_b);
        u_ctl.idle(RAS_CYC + RP_CYC);
        settle();
        `CHK(bank_open, 4'h0)
        // Single, idle-bank and all-bank precharge; mode load refused while open
        u_ctl.issue(1'b1, 1'b0, CMD_ACT, 2'h0, 13'h0001);
        u_ctl.issue(1'b1, 1'b0, CMD_ACT, 2'h2, 13'h0002);
        u_ctl.idle(RAS_CYC);
        u_ctl.issue(1'b1, 1'b0, CMD_PRE, 2'h0, 13'h0000);
        u_ctl.idle(RP_CYC);
        settle();
        `CHK(bank_open, 4'h4)
        u_ctl.issue(1'b1, 1'b0, CMD_PRE, 2'h3, 13'h0000);
        u_ctl.issue(1'b1, 1'b0, CMD_MRS, 2'h0, 13'h0123);
        settle();
        `CHK(bank_open, 4'h4)
        `CHK(mode_reg, 13'h0000)
        u_ctl.issue(1'b1, 1'b0, CMD_PRE, 2'h1, 13'h0400);
        u_ctl.idle(RP_CYC);
        settle();
        `CHK(bank_open, 4'h0)
        // Burst terminate keeps the row open
        u_ctl.idle(RP_CYC);
        u_ctl.issue(1'b1, 1'b0, CMD_ACT, 2'h0, 13'h0003);
        u_ctl.issue(1'b1, 1'b0, CMD_RD, 2'h0, 13'h0000);
        u_ctl.issue(1'b1, 1'b0, CMD_BST, 2'h0, 13'h0000);
        repeat (3) @(posedge mem_clk);
        @(negedge mem_clk);
        `CHK(dq_oe, 1'b0)
        `CHK(bank_open, 4'h1)
        u_ctl.idle(RAS_CYC);
        u_ctl.issue(1'b1, 1'b0, CMD_PRE, 2'h0, 13'h0000);
        u_ctl.idle(RP_CYC);
        // Standard, extended and reserved mode selects
        u_ctl.issue(1'b1, 1'b0, CMD_MRS, 2'h0, 13'h0123);
        u_ctl.idle(MRD_CYC);
        u_ctl.issue(1'b1, 1'b0, CMD_MRS, 2'h2, 13'h0456);
        u_ctl.idle(MRD_CYC);
        u_ctl.issue(1'b1, 1'b0, CMD_MRS, 2'h1, 13'h1FFF);
        settle();
        `CHK(mode_reg, 13'h0123)
        `CHK(ext_mode_reg, 13'h0456)
        // Two auto refreshes, each stepping the internal row by one
        u_ctl.issue(1'b1, 1'b0, CMD_REF, 2'h3, 13'h1ABC);
        u_ctl.idle(RFC_CYC);
        settle();
        r0 = refresh_row;
        u_ctl.issue(1'b1, 1'b0, CMD_REF, 2'h1, 13'h0555);
        u_ctl.idle(RFC_CYC);
        settle();
        `CHK(refresh_row, r0 + 13'h0001)
        // Self refresh ignores commands and refreshes on its own
        u_ctl.issue(1'b0, 1'b0, CMD_REF, 2'h0, 13'h0000);
        settle();
        `CHK(self_refresh, 1'b1)
        r0 = refresh_row;
        u_ctl.issue(1'b0, 1'b0, CMD_ACT, 2'h0, 13'h0007);
        u_ctl.idle(2 * SREF_INT_CYC + 4);
        settle();
        `CHK(bank_open, 4'h0)
        `CHK(refresh_row !== r0, 1'b1)
        u_ctl.issue(1'b1, 1'b0, CMD_NOP, 2'h0, 13'h0000);
        u_ctl.idle(RFC_CYC);
        settle();
        `CHK(self_refresh, 1'b0)
        // Deep power down and its exit
        u_ctl.issue(1'b0, 1'b0, CMD_BST, 2'h0, 13'h0000);
        settle();
        `CHK(deep_power_down, 1'b1)
        u_ctl.issue(1'b1, 1'b0, CMD_NOP, 2'h0, 13'h0000);
        u_ctl.idle(4);
        settle();
        `CHK(deep_power_down, 1'b0)
        `CHK(mode_reg, 13'h0000)
        stop_test();
    end
endmodule
